/* File: design/wake_event_enable_bank.sv */
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module wake_event_enable_bank #(
  parameter int unsigned IDX_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic standby_por_n,
  input wire logic soft_hard_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire wake_pkg::misc_src_t misc_src,
  input wire logic [7:0] gpio_g1,
  output logic shared_wake_out_n,
  output logic shared_wake_oe,
  output logic irq
);
  import wake_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (IDX_W < 4 || IDX_W > REG_IDX_W)
  begin : g_bad_idx
    $error("wake_event_enable_bank: IDX_W out of range");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg_wr_t wr; // Write from bus
  reg_rd_t rd; // Read from bus
  logic [31:0] rd_data; // Read mux

  // Standby-rail domain
  logic [7:0] wake_enable_misc_sources_reg;
  logic [7:0] wake_enable_gpio_group_one_reg;
  logic global_wake_enable_reg;

  // Main-supply domain
  logic [7:0] mask_misc_reg; // Interrupt mask, misc
  logic [7:0] mask_gpio_reg; // Interrupt mask, gpio

  logic [7:0] status_misc; // Sticky wake status, misc
  logic [7:0] status_gpio; // Sticky wake status, gpio
  logic [7:0] clear_misc; // Write-one-to-clear pulses
  logic [7:0] clear_gpio;

  logic [7:0] pend_misc; // Enabled and set, per source
  logic [7:0] pend_gpio;
  logic wake_next; // Output should pull low
  logic irq_next; // Unmasked status present

  // ----------------------------------------
  // Decode helper, used for every register
  // ----------------------------------------
  function automatic logic wr_hit(input reg_wr_t w, input logic [7:0] idx);
    return w.valid && (w.idx == idx);
  endfunction

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  ahb_reg_slave #(
    .IDX_W(IDX_W)
  ) u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr(wr),
    .rd(rd),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Enable registers
  // ----------------------------------------
  // Only the standby-rail reset clears them; hresetn and
  // soft/hard reset leave them alone so wake survives
  always_ff @(posedge hclk or negedge standby_por_n)
  begin
    if (!standby_por_n)
    begin
      wake_enable_misc_sources_reg <= ENABLE_RESET;
      wake_enable_gpio_group_one_reg <= ENABLE_RESET;
    end
    else
    begin
      // Reserved bit 0 never stores
      if (wr_hit(wr, IDX_ENABLE_MISC))
        wake_enable_misc_sources_reg <= wr.data[7:0] & MISC_VALID;
      // One bit per gpio pin, same index
      if (wr_hit(wr, IDX_ENABLE_GPIO))
        wake_enable_gpio_group_one_reg <= wr.data[7:0];
    end
  end

  // ----------------------------------------
  // Global enable, also on the standby rail
  // ----------------------------------------
  always_ff @(posedge hclk or negedge standby_por_n)
  begin
    if (!standby_por_n)
      global_wake_enable_reg <= 1'b0;
    else if (wr_hit(wr, IDX_CONTROL))
      global_wake_enable_reg <= wr.data[CTRL_GLOBAL_BIT];
  end

  // ----------------------------------------
  // Interrupt masks
  // ----------------------------------------
  // Main-supply state, so soft/hard reset clears it too
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_misc_reg <= MASK_RESET;
      mask_gpio_reg <= MASK_RESET;
    end
    else if (soft_hard_reset)
    begin
      mask_misc_reg <= MASK_RESET;
      mask_gpio_reg <= MASK_RESET;
    end
    else
    begin
      if (wr_hit(wr, IDX_MASK_MISC))
        mask_misc_reg <= wr.data[7:0] & MISC_VALID;
      if (wr_hit(wr, IDX_MASK_GPIO))
        mask_gpio_reg <= wr.data[7:0];
    end
  end

  // ----------------------------------------
  // Status capture
  // ----------------------------------------
  // Clear pulses only for a write hitting the status word
  assign clear_misc = wr_hit(wr, IDX_STATUS_MISC) ? wr.data[7:0] : STATUS_RESET;
  assign clear_gpio = wr_hit(wr, IDX_STATUS_GPIO) ? wr.data[7:0] : STATUS_RESET;

  // Events captured with enables ignored
  wake_status_capture #(
    .WIDTH(SRC_W),
    .VALID(MISC_VALID)
  ) u_status_misc (
    .clk(hclk),
    .standby_rst_n(standby_por_n),
    .event_in(misc_src),
    .clear_in(clear_misc),
    .status(status_misc)
  );

  wake_status_capture #(
    .WIDTH(SRC_W),
    .VALID(GPIO_VALID)
  ) u_status_gpio (
    .clk(hclk),
    .standby_rst_n(standby_por_n),
    .event_in(gpio_g1),
    .clear_in(clear_gpio),
    .status(status_gpio)
  );

  // ----------------------------------------
  // Wake gating, one gate per source
  // ----------------------------------------
  for (genvar i = 0; i < SRC_W; i++)
  begin : g_gate
    // Disabled source shows in status but stays off the bus
    assign pend_misc[i] = status_misc[i] & wake_enable_misc_sources_reg[i];
    assign pend_gpio[i] = status_gpio[i] & wake_enable_gpio_group_one_reg[i];
  end

  assign wake_next = global_wake_enable_reg && (|pend_misc || |pend_gpio);
  assign irq_next = |(status_misc & mask_misc_reg) || |(status_gpio & mask_gpio_reg);

  // ----------------------------------------
  // Shared wake output, open drain
  // ----------------------------------------
  // Flopped so the pin never glitches on a status clear
  always_ff @(posedge hclk or negedge standby_por_n)
  begin
    if (!standby_por_n)
    begin
      shared_wake_out_n <= 1'b1;
      shared_wake_oe <= 1'b0;
    end
    else
    begin
      shared_wake_out_n <= !wake_next;
      shared_wake_oe <= wake_next;
    end
  end

  // ----------------------------------------
  // Interrupt output, level
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= irq_next;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped words read zero; reserved bits read zero
  always_comb
  begin
    rd_data = READ_ZERO;
    if (rd.valid)
    begin
      case (rd.idx)
        IDX_STATUS_MISC: rd_data[7:0] = status_misc;
        IDX_STATUS_GPIO: rd_data[7:0] = status_gpio;
        IDX_CONTROL: rd_data[CTRL_GLOBAL_BIT] = global_wake_enable_reg;
        IDX_MASK_MISC: rd_data[7:0] = mask_misc_reg;
        IDX_MASK_GPIO: rd_data[7:0] = mask_gpio_reg;
        IDX_ENABLE_MISC: rd_data[7:0] = wake_enable_misc_sources_reg;
        IDX_ENABLE_GPIO: rd_data[7:0] = wake_enable_gpio_group_one_reg;
        default: rd_data = READ_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_wake_when_qualified:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      (global_wake_enable_reg && |pend_misc) |=> !shared_wake_out_n)
    else $error("wake output not driven for qualified source");

  a_disabled_no_wake:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      (pend_misc == 8'h00 && pend_gpio == 8'h00) |=> shared_wake_out_n)
    else $error("wake output driven with no enabled source");

  a_enable_keeps_reset:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      !hresetn |=> $stable(wake_enable_misc_sources_reg)
        && $stable(wake_enable_gpio_group_one_reg))
    else $error("enable register changed under main reset");

  a_enable_write_stores:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      wr_hit(wr, IDX_ENABLE_GPIO)
        |=> wake_enable_gpio_group_one_reg == $past(wr.data[7:0]))
    else $error("gpio enable write not stored");

  a_misc_bit_map:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      (global_wake_enable_reg && misc_src.keyboard_wake
        && wake_enable_misc_sources_reg[3]) |=> ##1 !shared_wake_out_n)
    else $error("keyboard bit does not gate keyboard wake");

  a_reserved_bit_zero:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      !wake_enable_misc_sources_reg[MISC_RSVD_BIT] && !status_misc[MISC_RSVD_BIT])
    else $error("reserved misc bit became set");

  a_gpio_bit_map:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      (global_wake_enable_reg && gpio_g1[5]
        && wake_enable_gpio_group_one_reg[5]) |=> ##1 !shared_wake_out_n)
    else $error("gpio pin 5 does not gate its wake");

  a_status_sets:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      gpio_g1[2] |=> status_gpio[2])
    else $error("gpio event not recorded in status");

  a_pin_consistent:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      (shared_wake_oe == !shared_wake_out_n)
        and (!global_wake_enable_reg |=> shared_wake_out_n))
    else $error("wake pin inconsistent or driven while disabled");

  // Gpio half of the wake gate, kept apart from the misc half
  a_gpio_wake_qualified:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      (global_wake_enable_reg && |pend_gpio) |=> !shared_wake_out_n)
    else $error("wake output not driven for qualified gpio source");

  // Misc enable keeps every source bit, drops the reserved one
  a_misc_enable_stores:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      wr_hit(wr, IDX_ENABLE_MISC)
        |=> wake_enable_misc_sources_reg == ($past(wr.data[7:0]) & MISC_VALID))
    else $error("misc enable write not stored");

  // Soft or hard reset alone must not touch the enables
  a_enable_keeps_soft:
    assert property (@(posedge hclk) disable iff (!standby_por_n)
      (soft_hard_reset && !wr.valid) |=> $stable(wake_enable_misc_sources_reg)
        && $stable(wake_enable_gpio_group_one_reg))
    else $error("enable register changed under soft reset");

endmodule
`default_nettype wire

/* File: design/wake_pkg.sv */
// Contract
// - Enabled, set, globally enabled source drives wake
// - Disabled source still records status, no wake
// - Enables clear only on standby-rail reset
// - Each enable bit except misc bit 0 gates one source
// - Misc bits 1-7: ring2, ring1, kbd, mouse, key, fans
// - Misc enable bit 0 reserved, unassigned
// - Second register bit i enables gpio pin i
// - Status sets on event regardless of enables
`default_nettype none
package wake_pkg;

  // ----------------------------------------
  // Register map, word index (byte = 4*index)
  // ----------------------------------------
  localparam int unsigned REG_IDX_W = 8;
  localparam logic [7:0] IDX_STATUS_MISC = 8'h01;
  localparam logic [7:0] IDX_STATUS_GPIO = 8'h02;
  localparam logic [7:0] IDX_CONTROL = 8'h03;
  localparam logic [7:0] IDX_MASK_MISC = 8'h04;
  localparam logic [7:0] IDX_MASK_GPIO = 8'h05;
  localparam logic [7:0] IDX_ENABLE_MISC = 8'h0a;
  localparam logic [7:0] IDX_ENABLE_GPIO = 8'h0b;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int unsigned SRC_W = 8;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MISC_VALID = 8'hfe;
  localparam logic [7:0] GPIO_VALID = 8'hff;
  localparam int unsigned CTRL_GLOBAL_BIT = 0;
  localparam int unsigned MISC_RSVD_BIT = 0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Misc wake sources, bit 7 down to bit 0
  typedef struct packed {
    logic fan_speed_input_two;
    logic fan_speed_input_one;
    logic specific_key_wake;
    logic pointing_wake;
    logic keyboard_wake;
    logic ring_indicate_port_one;
    logic ring_indicate_port_two;
    logic reserved;
  } misc_src_t;

  // Register write in its data phase
  typedef struct packed {
    logic valid;
    logic [7:0] idx;
    logic [31:0] data;
  } reg_wr_t;

  // Register read while the bus waits
  typedef struct packed {
    logic valid;
    logic [7:0] idx;
  } reg_rd_t;

  // Bus slave states
  typedef enum logic [1:0] {
    SL_IDLE = 2'b01,
    SL_RWAIT = 2'b10
  } slave_state_t;

endpackage
`default_nettype wire

/* File: design/wake_status_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module wake_status_capture #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] VALID = '1
) (
  input wire logic clk,
  input wire logic standby_rst_n,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] status
);
  import wake_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (WIDTH < 1 || WIDTH > 32)
  begin : g_bad_width
    $error("wake_status_capture: WIDTH out of range");
  end

  // ----------------------------------------
  // Sticky status, one flop per source
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    // Set beats a same-cycle clear so no event is lost
    always_ff @(posedge clk or negedge standby_rst_n)
    begin
      if (!standby_rst_n)
        status[i] <= 1'b0;
      else if (VALID[i] && event_in[i])
        status[i] <= 1'b1;
      else if (clear_in[i])
        status[i] <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: design/ahb_reg_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_slave #(
  parameter int unsigned IDX_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output wake_pkg::reg_wr_t wr,
  output wake_pkg::reg_rd_t rd,
  input wire logic [31:0] rd_data
);
  import wake_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (IDX_W < 4 || IDX_W > REG_IDX_W)
  begin : g_bad_idx
    $error("ahb_reg_slave: IDX_W out of range");
  end

  slave_state_t state_reg; // Read wait tracking
  logic wr_pend_reg; // Write in data phase
  logic [7:0] wr_idx_reg; // Its word index
  logic [7:0] addr_idx; // Index of address phase
  logic take; // Address phase accepted

  assign addr_idx = REG_IDX_W'(haddr[IDX_W+1:2]);
  assign take = hsel && htrans[1] && hready;

  // Write data arrives in the data phase, one cycle on
  assign wr = '{valid: wr_pend_reg, idx: wr_idx_reg, data: hwdata};
  assign rd = '{valid: (state_reg == SL_RWAIT), idx: wr_idx_reg};

  // ----------------------------------------
  // Address phase capture
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end
    else
    begin
      // Sub-word writes are ignored, not merged
      wr_pend_reg <= take && hwrite && (hsize == HSIZE_WORD);
      if (take)
        wr_idx_reg <= addr_idx;
    end
  end

  // ----------------------------------------
  // Read wait: one stall so a write just ahead is seen
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= SL_IDLE;
      hreadyout <= 1'b1;
      hrdata <= READ_ZERO;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0; // Always OKAY
      case (state_reg)
        SL_IDLE:
        begin
          if (take && !hwrite)
          begin
            state_reg <= SL_RWAIT;
            hreadyout <= 1'b0;
          end
        end
        SL_RWAIT:
        begin
          state_reg <= SL_IDLE;
          hreadyout <= 1'b1;
          hrdata <= rd_data;
        end
        default:
        begin
          state_reg <= SL_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: dv/wake_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Chipset wake input with pull-up
// ----------------------------------------
module wake_sink_model
(
  input wire logic hclk,
  input wire logic rst_n,
  input wire logic drive_en,
  input wire logic drive_val,
  output logic wake_line,
  output logic [7:0] wake_seen
);
  logic prev_line; // Last sampled line level

  // Open drain: released line floats up to 1
  assign wake_line = drive_en ? drive_val : 1'b1;

  // Count each new wake request, the way the chipset would latch it
  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_line <= 1'b1;
      wake_seen <= 8'h00;
    end
    else
    begin
      prev_line <= wake_line;
      if (prev_line && !wake_line)
        wake_seen <= wake_seen + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: dv/wake_event_enable_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module wake_event_enable_bank_tb;
  import wake_pkg::*;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  logic hclk, hresetn, standby_por_n, soft_hard_reset;
  logic hsel, hwrite, hreadyout, hresp, wake_n, wake_oe, irq, wake_line;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] ev; // Bit 8+i drives gpio pin i
  logic [15:0] en; // Enable pattern under test
  logic [7:0] wake_seen;
  int mismatches, n_checks, o;

  wake_event_enable_bank i_wake_event_enable_bank (.hclk(hclk), .hresetn(hresetn),
    .standby_por_n(standby_por_n), .soft_hard_reset(soft_hard_reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .misc_src(misc_src_t'(ev[7:0])), .gpio_g1(ev[15:8]), .shared_wake_out_n(wake_n),
    .shared_wake_oe(wake_oe), .irq(irq));

  wake_sink_model i_wake_sink_model (.hclk(hclk), .rst_n(standby_por_n), .drive_en(wake_oe),
    .drive_val(wake_n), .wake_line(wake_line), .wake_seen(wake_seen));

  // Free running 40 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] addr(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single AHB transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic wchk(input string what, input logic exp);
    check(what, {31'h0, wake_line}, {31'h0, exp});
  endtask

  // Drop events first, since a source still high would set its status again
  task automatic clear_all;
    ev <= 16'h0;
    bus(1'b1, addr(IDX_STATUS_MISC), 32'hff);
    bus(1'b1, addr(IDX_STATUS_GPIO), 32'hff);
  endtask

  task automatic close_out;
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial
  begin
    #(25 * 40000);
    mismatches++;
    close_out;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {hresetn, standby_por_n, soft_hard_reset, hsel, hwrite} = 5'b0;
    {haddr, hwdata, htrans, hsize, ev, en} = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    standby_por_n <= 1'b1;
    rd_chk("en_misc reset", addr(IDX_ENABLE_MISC), 32'h0);
    rd_chk("en_gpio reset", addr(IDX_ENABLE_GPIO), 32'h0);
    rd_chk("unmapped", 32'h0000_0024, 32'h0);
    bus(1'b1, addr(IDX_ENABLE_MISC), 32'hff);
    bus(1'b1, addr(IDX_ENABLE_GPIO), 32'hff);
    rd_chk("en_misc rsvd", addr(IDX_ENABLE_MISC), 32'hfe);
    rd_chk("en_gpio all", addr(IDX_ENABLE_GPIO), 32'hff);
    // Disabled sources still latch status
    bus(1'b1, addr(IDX_ENABLE_MISC), 32'h0);
    bus(1'b1, addr(IDX_ENABLE_GPIO), 32'h0);
    // Global on, so only the enables keep the pin released
    bus(1'b1, addr(IDX_CONTROL), 32'h1);
    ev <= 16'hffff;
    wait_n(4);
    rd_chk("sts_misc", addr(IDX_STATUS_MISC), 32'hfe);
    rd_chk("sts_gpio", addr(IDX_STATUS_GPIO), 32'hff);
    wchk("wake disabled", 1'b1);
    bus(1'b1, addr(IDX_CONTROL), 32'h0);
    bus(1'b1, addr(IDX_ENABLE_MISC), 32'hff);
    bus(1'b1, addr(IDX_ENABLE_GPIO), 32'hff);
    wait_n(3);
    wchk("wake no global", 1'b1);
    bus(1'b1, addr(IDX_CONTROL), 32'h1);
    wait_n(3);
    wchk("wake global", 1'b0);
    clear_all;
    wait_n(3);
    wchk("wake cleared", 1'b1);
    // One source at a time, with a neighbour as decoy
    for (int i = 1; i < 16; i++)
    begin
      en = 16'h1 << i;
      o = (i == 15) ? 1 : i + 1;
      bus(1'b1, addr(IDX_ENABLE_MISC), {24'h0, en[7:0]});
      bus(1'b1, addr(IDX_ENABLE_GPIO), {24'h0, en[15:8]});
      ev <= 16'h1 << o;
      wait_n(4);
      wchk("wake decoy", 1'b1);
      ev <= (16'h1 << o) | en;
      wait_n(4);
      wchk("wake own", 1'b0);
      clear_all;
      wait_n(3);
      wchk("wake release", 1'b1);
    end
    check("wake count", {24'h0, wake_seen}, 32'h10);
    // Reserved bit routes nothing
    bus(1'b1, addr(IDX_ENABLE_MISC), 32'h01);
    bus(1'b1, addr(IDX_ENABLE_GPIO), 32'h0);
    ev <= 16'h0001;
    wait_n(4);
    wchk("wake rsvd", 1'b1);
    rd_chk("sts rsvd", addr(IDX_STATUS_MISC), 32'h0);
    // Interrupt raised, masked and cleared
    bus(1'b1, addr(IDX_MASK_MISC), 32'h04);
    ev <= 16'h0008;
    wait_n(4);
    check("irq masked", {31'h0, irq}, 32'h0);
    ev <= 16'h000c;
    wait_n(4);
    check("irq set", {31'h0, irq}, 32'h1);
    clear_all;
    wait_n(3);
    check("irq clear", {31'h0, irq}, 32'h0);
    // Main and soft resets leave enables, standby reset clears them
    bus(1'b1, addr(IDX_ENABLE_MISC), 32'haa);
    bus(1'b1, addr(IDX_ENABLE_GPIO), 32'h55);
    hresetn <= 1'b0;
    wait_n(2);
    hresetn <= 1'b1;
    soft_hard_reset <= 1'b1;
    wait_n(1);
    soft_hard_reset <= 1'b0;
    rd_chk("en_misc kept", addr(IDX_ENABLE_MISC), 32'haa);
    rd_chk("en_gpio kept", addr(IDX_ENABLE_GPIO), 32'h55);
    standby_por_n <= 1'b0;
    wait_n(2);
    standby_por_n <= 1'b1;
    rd_chk("en_misc por", addr(IDX_ENABLE_MISC), 32'h0);
    rd_chk("en_gpio por", addr(IDX_ENABLE_GPIO), 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
